// *** core/tmd_device.sv ***
// Transceiver end: mode control registers, demodulator, bit-rate clock,
// bit synchronizer and the serial data port. Clock is the crystal reference.
// Assumes the host keeps its data pin released until it sends bits.
`timescale 1ns/1ps
`default_nettype none
module tmd_device (
  input  wire logic clk,
  input  wire logic nrst,
  tmd_link_if.dev   link,
  input  wire logic i_chan,
  input  wire logic q_chan,
  output logic      front_amp_skip,
  output logic      xtal_run,
  output logic      rx_active,
  output logic      tx_active,
  output logic      bit_sync_on,
  output logic      signal_level_enable,
  output logic      lock_detect_enable,
  output logic [1:0] fsk_method_sel,
  output logic [2:0] tx_power_level,
  output logic      load_flag,
  output logic [8:0] prefilter_cutoff_khz,
  output logic      mod_data
);
  logic [7:0] op_ctrl;
  logic [7:0] mod_pf;
  logic [7:0] clk_scale;
  logic [7:0] rate_div;
  tmd_pkg::tmd_state_t operating_state_sel;
  logic        sync_en;
  logic [2:0]  rate_exponent;
  logic [2:0]  sync_clock_exponent;
  logic [5:0]  ref_k;
  logic [12:0] rate_period;
  logic [12:0] sync_period;
  logic [12:0] br_cnt;
  logic        br_clk;
  logic [12:0] sy_cnt;
  logic        sy_tick;
  logic [2:0]  i_sr;
  logic [2:0]  q_sr;
  logic [2:0]  d_sr;
  logic        i_f;
  logic        q_f;
  logic        d_f;
  logic        demod_bit;
  logic [3:0]  ph;
  logic [3:0]  next_ph;
  logic        last_bit;
  logic        held_bit;
  logic        next_dclk;
  logic        dclk_rise;

  function automatic logic [12:0] tmd_period(input logic [5:0] k, input logic [2:0] e);
    logic [5:0] kk;
    kk = (k < tmd_pkg::REF_DIV_MIN) ? tmd_pkg::REF_DIV_MIN : k;
    tmd_period = {7'h00, kk} << (tmd_pkg::SCALE_BASE - e);
  endfunction

  function automatic logic [7:0] tmd_read(input logic [2:0] a, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r6,
                                          input logic [7:0] r7);
    unique case (a)
      tmd_pkg::REG_OP_CTRL:   tmd_read = r0;
      tmd_pkg::REG_MOD_PF:    tmd_read = r1 & tmd_pkg::MP_USED_MASK;
      tmd_pkg::REG_CLK_SCALE: tmd_read = r6 & tmd_pkg::CS_USED_MASK;
      tmd_pkg::REG_RATE_DIV:  tmd_read = r7;
      default:                tmd_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_ctrl   <= tmd_pkg::REG_RESET;
      mod_pf    <= tmd_pkg::REG_RESET;
      clk_scale <= tmd_pkg::REG_RESET;
      rate_div  <= tmd_pkg::REG_RESET;
    end else if (link.reg_wr) begin
      if (link.reg_addr == tmd_pkg::REG_OP_CTRL) op_ctrl <= link.reg_wdata;
      if (link.reg_addr == tmd_pkg::REG_MOD_PF) mod_pf <= link.reg_wdata;
      if (link.reg_addr == tmd_pkg::REG_CLK_SCALE) clk_scale <= link.reg_wdata;
      if (link.reg_addr == tmd_pkg::REG_RATE_DIV) rate_div <= link.reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.reg_rdata <= 8'h00;
    end else begin
      link.reg_rdata <= link.reg_rd ? tmd_read(link.reg_addr, op_ctrl, mod_pf, clk_scale, rate_div)
                                    : 8'h00;
    end
  end

  always_comb begin
    operating_state_sel = tmd_pkg::tmd_state_t'(op_ctrl[tmd_pkg::OP_STATE_LSB +: 2]);
    sync_en             = op_ctrl[tmd_pkg::OP_SYNC_BIT];
    rate_exponent       = {clk_scale[tmd_pkg::CS_RATE_HI_BIT], rate_div[tmd_pkg::RD_RATE_LSB +: 2]};
    if (rate_exponent > tmd_pkg::RATE_EXP_MAX) rate_exponent = tmd_pkg::RATE_EXP_MAX;
    sync_clock_exponent = clk_scale[tmd_pkg::CS_SYNC_LSB +: 3];
    if (sync_clock_exponent > tmd_pkg::RATE_EXP_MAX) sync_clock_exponent = tmd_pkg::RATE_EXP_MAX;
    ref_k       = rate_div[tmd_pkg::RD_DIV_LSB +: 6];
    rate_period = tmd_period(ref_k, rate_exponent);
    // tick rate set by its own exponent
    sync_period = tmd_period(ref_k, sync_clock_exponent);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      front_amp_skip       <= 1'b0;
      xtal_run             <= 1'b0;
      rx_active            <= 1'b0;
      tx_active            <= 1'b0;
      bit_sync_on          <= 1'b0;
      signal_level_enable  <= 1'b0;
      lock_detect_enable   <= 1'b0;
      fsk_method_sel       <= 2'h0;
      tx_power_level       <= 3'h0;
      load_flag            <= 1'b0;
    end else begin
      front_amp_skip       <= op_ctrl[tmd_pkg::OP_SKIP_BIT];
      xtal_run             <= operating_state_sel != tmd_pkg::ST_POWER_DOWN;
      rx_active            <= operating_state_sel == tmd_pkg::ST_RECEIVE;
      tx_active            <= operating_state_sel == tmd_pkg::ST_TRANSMIT;
      bit_sync_on          <= (operating_state_sel == tmd_pkg::ST_RECEIVE) && sync_en;
      signal_level_enable  <= mod_pf[tmd_pkg::MP_RSSI_BIT];
      lock_detect_enable   <= mod_pf[tmd_pkg::MP_LD_BIT];
      fsk_method_sel       <= mod_pf[tmd_pkg::MP_METHOD_LSB +: 2];
      tx_power_level       <= op_ctrl[tmd_pkg::OP_PWR_LSB +: 3];
      load_flag            <= op_ctrl[tmd_pkg::OP_LOAD_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prefilter_cutoff_khz <= tmd_pkg::CUT_00;
    end else begin
      unique case (mod_pf[tmd_pkg::MP_CUTOFF_LSB +: 2])
        2'b00: prefilter_cutoff_khz <= tmd_pkg::CUT_00;
        2'b01: prefilter_cutoff_khz <= tmd_pkg::CUT_01;
        2'b10: prefilter_cutoff_khz <= tmd_pkg::CUT_10;
        2'b11: prefilter_cutoff_khz <= tmd_pkg::CUT_11;
      endcase
    end
  end

  // Pin inputs: three stages, change taken when last two agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      i_sr <= 3'h0;
      q_sr <= 3'h0;
      d_sr <= 3'h0;
      i_f  <= 1'b0;
      q_f  <= 1'b0;
      d_f  <= 1'b0;
    end else begin
      i_sr <= {i_sr[1:0], i_chan};
      q_sr <= {q_sr[1:0], q_chan};
      d_sr <= {d_sr[1:0], link.data_io_pin};
      if (i_sr[2] == i_sr[1]) i_f <= i_sr[2];
      if (q_sr[2] == q_sr[1]) q_f <= q_sr[2];
      if (d_sr[2] == d_sr[1]) d_f <= d_sr[2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      demod_bit <= 1'b0;
    end else if ((i_sr[2] == i_sr[1]) && i_sr[2] && !i_f) begin
      demod_bit <= q_f;
    end else if ((q_sr[2] == q_sr[1]) && q_sr[2] && !q_f) begin
      demod_bit <= ~i_f;
    end
  end

  // half period each level, one bit per clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      br_cnt <= 13'h0000;
      br_clk <= 1'b0;
    end else if (operating_state_sel == tmd_pkg::ST_TRANSMIT && sync_en) begin
      if (br_cnt >= (rate_period >> 1) - 13'h0001) begin
        br_cnt <= 13'h0000;
        br_clk <= ~br_clk;
      end else begin
        br_cnt <= br_cnt + 13'h0001;
      end
    end else begin
      br_cnt <= 13'h0000;
      br_clk <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy_cnt  <= 13'h0000;
      sy_tick <= 1'b0;
    end else if (operating_state_sel == tmd_pkg::ST_RECEIVE && sync_en) begin
      sy_tick <= sy_cnt >= sync_period - 13'h0001;
      sy_cnt  <= (sy_cnt >= sync_period - 13'h0001) ? 13'h0000 : sy_cnt + 13'h0001;
    end else begin
      sy_cnt  <= 13'h0000;
      sy_tick <= 1'b0;
    end
  end

  // Sixteen ticks per bit; a data edge restarts the phase so the
  // centre sample sits mid-bit. Jittery input only costs alignment.
  always_comb begin
    next_ph = ph;
    if (sy_tick) next_ph = (demod_bit != last_bit) ? tmd_pkg::SYNC_RESTART : ph + 4'h1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph       <= 4'h0;
      last_bit <= 1'b0;
      held_bit <= 1'b0;
    end else if (operating_state_sel == tmd_pkg::ST_RECEIVE && sync_en) begin
      ph <= next_ph;
      if (sy_tick) last_bit <= demod_bit;
      if (sy_tick && next_ph == tmd_pkg::SYNC_CENTRE) held_bit <= demod_bit;
    end else begin
      ph       <= 4'h0;
      last_bit <= demod_bit;
      held_bit <= 1'b0;
    end
  end

  // clock generated here, never taken in
  // receive clock period is eight ticks
  // clock held low when not synchronous
  always_comb begin
    next_dclk = 1'b0;
    if (sync_en && operating_state_sel == tmd_pkg::ST_TRANSMIT) next_dclk = br_clk;
    if (sync_en && operating_state_sel == tmd_pkg::ST_RECEIVE) next_dclk = next_ph[2];
    dclk_rise = next_dclk && !link.data_bit_clock;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) link.data_bit_clock <= 1'b0;
    else link.data_bit_clock <= next_dclk;
  end

  // new bit on every second clock rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.dev_data_out <= 1'b0;
      link.dev_data_oe  <= 1'b0;
    end else begin
      link.dev_data_oe <= operating_state_sel == tmd_pkg::ST_RECEIVE;
      if (!sync_en) link.dev_data_out <= demod_bit;
      else if (dclk_rise) link.dev_data_out <= held_bit;
    end
  end

  // relies on host releasing the pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mod_data <= 1'b0;
    end else if (operating_state_sel != tmd_pkg::ST_TRANSMIT) begin
      mod_data <= 1'b0;
    end else if (!sync_en || dclk_rise) begin
      mod_data <= d_f;
    end
  end
endmodule
`default_nettype wire

// *** core/tmd_pkg.sv ***
// Shared constants for the transceiver mode and data port.
// Assumes one clock (the crystal reference) on both ends.
package tmd_pkg;
  // Register offsets in the device
  localparam logic [2:0] REG_OP_CTRL   = 3'h0;
  localparam logic [2:0] REG_MOD_PF    = 3'h1;
  localparam logic [2:0] REG_CLK_SCALE = 3'h6;
  localparam logic [2:0] REG_RATE_DIV  = 3'h7;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // Field positions, operating_control
  localparam int OP_LOAD_BIT  = 0;
  localparam int OP_STATE_LSB = 1;
  localparam int OP_SYNC_BIT  = 3;
  localparam int OP_PWR_LSB   = 4;
  localparam int OP_SKIP_BIT  = 7;
  // Field positions, modulation_and_prefilter_control
  localparam int MP_CUTOFF_LSB = 0;
  localparam int MP_LD_BIT     = 2;
  localparam int MP_RSSI_BIT   = 3;
  localparam int MP_METHOD_LSB = 6;
  localparam logic [7:0] MP_USED_MASK = 8'hCF;
  // Field positions, clock_scaler_select and rate_and_reference_divider
  localparam int CS_RATE_HI_BIT = 0;
  localparam int CS_SYNC_LSB    = 1;
  localparam int CS_MOD_LSB     = 4;
  localparam logic [7:0] CS_USED_MASK = 8'h7F;
  localparam int RD_DIV_LSB     = 0;
  localparam int RD_RATE_LSB    = 6;
  // Rate exponent limits and scaler base
  localparam logic [2:0] RATE_EXP_MAX = 3'h6;
  localparam logic [2:0] SCALE_BASE   = 3'h7;
  localparam logic [5:0] REF_DIV_MIN  = 6'h01;
  // Bit synchronizer
  localparam logic [3:0] SYNC_TICKS_LAST = 4'hF;
  localparam logic [3:0] SYNC_RESTART    = 4'h1;
  localparam logic [3:0] SYNC_CENTRE     = 4'h8;
  // Prefilter cutoffs in kHz
  localparam logic [8:0] CUT_00 = 9'h064;
  localparam logic [8:0] CUT_01 = 9'h096;
  localparam logic [8:0] CUT_10 = 9'h0E6;
  localparam logic [8:0] CUT_11 = 9'h154;
  // Host side register map
  localparam logic [3:0] HREG_CTRL  = 4'h8;
  localparam logic [3:0] HREG_TXD   = 4'h9;
  localparam logic [3:0] HREG_RXD   = 4'hA;
  localparam logic [3:0] HREG_STAT  = 4'hB;
  localparam logic [3:0] HREG_DEVRD = 4'hC;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {
    ST_POWER_DOWN = 2'b00,
    ST_STANDBY    = 2'b01,
    ST_RECEIVE    = 2'b10,
    ST_TRANSMIT   = 2'b11
  } tmd_state_t;
endpackage

// *** core/tmd_link_if.sv ***
// Link between the transceiver data port and its host controller.
// The shared data pin resolves here; an undriven pin reads high.
`timescale 1ns/1ps
`default_nettype none
interface tmd_link_if;
  logic       data_bit_clock;
  logic       dev_data_out;
  logic       dev_data_oe;
  logic       host_data_out;
  logic       host_data_oe;
  logic       data_io_pin;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;

  assign data_io_pin = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 1'b1);

  modport dev (
    output data_bit_clock,
    output dev_data_out,
    output dev_data_oe,
    output reg_rdata,
    input  data_io_pin,
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd
  );
  modport host (
    input  data_bit_clock,
    input  data_io_pin,
    input  reg_rdata,
    output host_data_out,
    output host_data_oe,
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd
  );
endinterface
`default_nettype wire

// *** core/tmd_host.sv ***
// Host controller end: software register port, device register access,
// byte-wide serial send and receive on the device's data clock.
// Assumes the device is clock master and one clock for both ends.
`timescale 1ns/1ps
`default_nettype none
module tmd_host (
  input  wire logic       clk,
  input  wire logic       nrst,
  tmd_link_if.host        link,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata
);
  logic [2:0] ck_sr;
  logic [2:0] d_sr;
  logic       ck_f;
  logic       d_f;
  logic       fall;
  logic       rx_en;
  logic [7:0] tx_byte;
  logic [7:0] tx_sh;
  logic [3:0] tx_cnt;
  logic       tx_busy;
  logic       tx_done;
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic [3:0] rx_cnt;
  logic       rx_half;
  logic       rx_ready;
  logic       rd_wait;
  logic [7:0] dev_rd_data;
  logic       ctrl_wr;
  logic       stat_wr;
  logic       rx_store;

  always_comb begin
    ctrl_wr  = sw_wr && sw_addr == tmd_pkg::HREG_CTRL;
    stat_wr  = sw_wr && sw_addr == tmd_pkg::HREG_STAT;
    fall     = ck_f && (ck_sr[2] == ck_sr[1]) && !ck_sr[2];
    rx_store = fall && rx_en && rx_half && rx_cnt == tmd_pkg::BITS_PER_BYTE - 4'h1;
  end

  // Clock and data pins pass three stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_sr <= 3'h0;
      d_sr  <= 3'h0;
      ck_f  <= 1'b0;
      d_f   <= 1'b0;
    end else begin
      ck_sr <= {ck_sr[1:0], link.data_bit_clock};
      d_sr  <= {d_sr[1:0], link.data_io_pin};
      if (ck_sr[2] == ck_sr[1]) ck_f <= ck_sr[2];
      if (d_sr[2] == d_sr[1]) d_f <= d_sr[2];
    end
  end

  // Device register access, one cycle behind software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.reg_addr  <= 3'h0;
      link.reg_wdata <= 8'h00;
      link.reg_wr    <= 1'b0;
      link.reg_rd    <= 1'b0;
      rd_wait        <= 1'b0;
      dev_rd_data    <= 8'h00;
    end else begin
      link.reg_wr <= sw_wr && !sw_addr[3];
      link.reg_rd <= sw_wr && sw_addr == tmd_pkg::HREG_DEVRD;
      if (sw_wr && !sw_addr[3]) begin
        link.reg_addr  <= sw_addr[2:0];
        link.reg_wdata <= sw_wdata;
      end else if (sw_wr && sw_addr == tmd_pkg::HREG_DEVRD) begin
        link.reg_addr <= sw_wdata[2:0];
      end
      rd_wait <= link.reg_rd;
      if (rd_wait) dev_rd_data <= link.reg_rdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_en   <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      if (ctrl_wr) rx_en <= sw_wdata[1];
      if (sw_wr && sw_addr == tmd_pkg::HREG_TXD) tx_byte <= sw_wdata;
    end
  end

  // bit changes only on falling edges
  // pin released until the first bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh              <= 8'h00;
      tx_cnt             <= 4'h0;
      tx_busy            <= 1'b0;
      link.host_data_out <= 1'b0;
      link.host_data_oe  <= 1'b0;
    end else if (ctrl_wr && sw_wdata[0] && !tx_busy) begin
      tx_sh   <= tx_byte;
      tx_cnt  <= 4'h0;
      tx_busy <= 1'b1;
    end else if (tx_busy && fall) begin
      if (tx_cnt == tmd_pkg::BITS_PER_BYTE) begin
        tx_busy           <= 1'b0;
        link.host_data_oe <= 1'b0;
      end else begin
        link.host_data_out <= tx_sh[7];
        link.host_data_oe  <= 1'b1;
        tx_sh              <= {tx_sh[6:0], 1'b0};
        tx_cnt             <= tx_cnt + 4'h1;
      end
    end
  end

  // sample on falling edges, every second one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sh   <= 8'h00;
      rx_byte <= 8'h00;
      rx_cnt  <= 4'h0;
      rx_half <= 1'b0;
    end else if (!rx_en) begin
      rx_cnt  <= 4'h0;
      rx_half <= 1'b0;
    end else if (fall) begin
      rx_half <= ~rx_half;
      if (rx_half) begin
        rx_sh  <= {rx_sh[6:0], d_f};
        rx_cnt <= rx_store ? 4'h0 : rx_cnt + 4'h1;
        if (rx_store) rx_byte <= {rx_sh[6:0], d_f};
      end
    end
  end

  // Sticky flags: a new event beats a write-one clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_done  <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      if (tx_busy && fall && tx_cnt == tmd_pkg::BITS_PER_BYTE) tx_done <= 1'b1;
      else if (stat_wr && sw_wdata[1]) tx_done <= 1'b0;
      if (rx_store) rx_ready <= 1'b1;
      else if (stat_wr && sw_wdata[2]) rx_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_rdata <= 8'h00;
    end else if (!sw_rd) begin
      sw_rdata <= 8'h00;
    end else begin
      unique case (sw_addr)
        tmd_pkg::HREG_CTRL:  sw_rdata <= {6'h00, rx_en, 1'b0};
        tmd_pkg::HREG_TXD:   sw_rdata <= tx_byte;
        tmd_pkg::HREG_RXD:   sw_rdata <= rx_byte;
        tmd_pkg::HREG_STAT:  sw_rdata <= {5'h00, rx_ready, tx_done, tx_busy};
        tmd_pkg::HREG_DEVRD: sw_rdata <= dev_rd_data;
        default:             sw_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test/tmd_link_props.sv ***
// Assertions on the link between the transceiver end and the host end.
// Assumes one clock and the register writes seen on the link as the only config path.
`timescale 1ns/1ps
`default_nettype none
module tmd_link_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       data_bit_clock,
  input wire logic       dev_data_out,
  input wire logic       dev_data_oe,
  input wire logic       host_data_out,
  input wire logic       host_data_oe,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] sh0;
  logic [7:0] sh1;
  logic [7:0] sh6;
  logic [7:0] sh7;
  logic [7:0] exp_rd;
  logic [1:0] settle;

  // Shadow copy of the device registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh0 <= 8'h00;
      sh1 <= 8'h00;
      sh6 <= 8'h00;
      sh7 <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 3'h0) sh0 <= reg_wdata;
      if (reg_addr == 3'h1) sh1 <= reg_wdata;
      if (reg_addr == 3'h6) sh6 <= reg_wdata;
      if (reg_addr == 3'h7) sh7 <= reg_wdata;
    end
  end

  // Outputs lag a write; only judge them once it has settled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) settle <= 2'h0;
    else if (reg_wr) settle <= 2'h0;
    else if (settle != 2'h3) settle <= settle + 2'h1;
  end

  always_comb begin
    case (reg_addr)
      3'h0: exp_rd = sh0;
      3'h1: exp_rd = sh1 & tmd_pkg::MP_USED_MASK;
      3'h6: exp_rd = sh6 & tmd_pkg::CS_USED_MASK;
      3'h7: exp_rd = sh7;
      default: exp_rd = 8'h00;
    endcase
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rd_req;
    reg_rd;
  endsequence
  sequence s_rd_ans;
    ##1 reg_rdata == $past(exp_rd);
  endsequence

  a_read_back: assert property (s_rd_req |-> s_rd_ans)
    else $error("register read data wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_read: assert property (reg_rd && (reg_addr[2:1] == 2'b01 || reg_addr[2:1] == 2'b10)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_clock_off_async: assert property (settle == 2'h3 && !(sh0[3] && sh0[2]) |-> !data_bit_clock)
    else $error("data clock running outside sync mode");
  a_rx_drive_pin: assert property (settle == 2'h3 |-> dev_data_oe == (sh0[2:1] == 2'b10))
    else $error("device pin drive wrong for state");
  a_no_contend: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data pin");
  a_host_tx_only: assert property (host_data_oe |-> sh0[2:1] == 2'b11)
    else $error("host drives pin outside transmit");
  a_host_falls: assert property (($rose(host_data_oe) || host_data_oe && $changed(host_data_out))
    |-> !data_bit_clock)
    else $error("host changed data while clock high");
  a_rx_on_rise: assert property (settle == 2'h3 && sh0[3:1] == 3'b110 && $changed(dev_data_out)
    |-> $rose(data_bit_clock))
    else $error("receive bit changed off a clock rise");
endmodule
`default_nettype wire

// *** test/transceiver_mode_and_data_port_bench.sv ***
// Bench for both ends joined by the link; drives the host software port and I/Q pins.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t got %0h exp %0h", $time, got, exp); end end
module transceiver_mode_and_data_port_bench;
  logic       clk = 1'b0;
  logic       nrst, sw_wr, sw_rd, i_chan, q_chan;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, v, d, b;
  logic       skip, xtal, rxa, txa, bsync, rssi, ld, load, mdat;
  logic [1:0] meth, s;
  logic [2:0] pwr;
  logic [8:0] cut;
  logic [8:0] cuts [4] = '{tmd_pkg::CUT_00, tmd_pkg::CUT_01, tmd_pkg::CUT_10, tmd_pkg::CUT_11};
  int         fails = 0, total_checks = 0, i, n;

  always #4 clk = ~clk;
  tmd_link_if lnk ();
  tmd_device i_tmd_device (.clk(clk), .nrst(nrst), .link(lnk), .i_chan(i_chan), .q_chan(q_chan),
    .front_amp_skip(skip), .xtal_run(xtal), .rx_active(rxa), .tx_active(txa),
    .bit_sync_on(bsync), .signal_level_enable(rssi), .lock_detect_enable(ld),
    .fsk_method_sel(meth), .tx_power_level(pwr), .load_flag(load),
    .prefilter_cutoff_khz(cut), .mod_data(mdat));
  tmd_host i_tmd_host (.clk(clk), .nrst(nrst), .link(lnk), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  tmd_link_props i_props (.clk(clk), .nrst(nrst), .data_bit_clock(lnk.data_bit_clock),
    .dev_data_out(lnk.dev_data_out), .dev_data_oe(lnk.dev_data_oe),
    .host_data_out(lnk.host_data_out), .host_data_oe(lnk.host_data_oe),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr),
    .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata));

  task wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= x;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 q = sw_rdata;
  endtask
  task dev_rd(input logic [2:0] a, output logic [7:0] q);
    wr(tmd_pkg::HREG_DEVRD, {5'h00, a});
    repeat (4) @(posedge clk);
    rd(tmd_pkg::HREG_DEVRD, q);
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Cycles until the next rise of the data clock, bounded
  task rise(output int c);
    logic p;
    c = 0;
    p = 1'b1;
    while (c < 400 && !(lnk.data_bit_clock === 1'b1 && p === 1'b0)) begin
      p = lnk.data_bit_clock;
      wt(1);
      c++;
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {sw_addr, sw_wdata, sw_wr, sw_rd, i_chan, q_chan} = '0;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wt(1);
    `CHK(cut, tmd_pkg::CUT_00)
    `CHK(xtal, 1'b0)
    for (i = 0; i < 8; i++) begin
      if (i < 2 || i > 5) begin
        dev_rd(3'(i), d);
        `CHK(d, tmd_pkg::REG_RESET)
      end
    end
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      s = 2'(i);
      v = {s[0], 1'b0, s, 1'b0, s, s[1]};
      wr(4'h0, v);
      wt(4);
      `CHK({xtal, rxa, txa}, {s != 2'b00, s == 2'b10, s == 2'b11})
      `CHK({skip, pwr, load}, {s[0], 1'b0, s, s[1]})
      dev_rd(3'h0, d);
      `CHK(d, v)
      v = {s, 2'b11, s[1], s[0], s};
      wr(4'h1, v);
      wt(4);
      `CHK({cut, meth, rssi, ld}, {cuts[i], s, s[1], s[0]})
      dev_rd(3'h1, d);
      `CHK(d, v & tmd_pkg::MP_USED_MASK)
    end
    wr(4'h3, 8'hFF);
    dev_rd(3'h3, d);
    `CHK(d, 8'h00)
    wr(4'h6, 8'hFF);
    dev_rd(3'h6, d);
    `CHK(d, 8'h7F)
    $display("test registers done");
    wr(4'h0, 8'h04);
    @(posedge clk) q_chan <= 1'b1;
    @(posedge clk) i_chan <= 1'b1;
    wt(10);
    `CHK({lnk.data_io_pin, lnk.data_bit_clock}, 2'b10)
    @(posedge clk) q_chan <= 1'b0;
    wt(4);
    @(posedge clk) q_chan <= 1'b1;
    wt(10);
    `CHK(lnk.data_io_pin, 1'b0)
    wr(4'h0, 8'h06);
    wt(8);
    `CHK({mdat, lnk.data_bit_clock}, 2'b10)
    $display("test async done");
    // Half period of 16 leaves room for both synchronisers before the rise
    wr(4'h6, 8'h01);
    wr(4'h7, 8'h48);
    wr(4'h0, 8'h0E);
    wr(tmd_pkg::HREG_TXD, 8'h5A);
    wr(tmd_pkg::HREG_CTRL, 8'h01);
    for (i = 0; i < 20 && mdat !== 1'b0; i++) rise(n);
    b = 8'h00;
    for (i = 0; i < 7; i++) begin
      rise(n);
      b = {b[6:0], mdat};
    end
    `CHK(n, 32)
    `CHK(b, 8'h5A)
    for (i = 0; i < 60; i++) begin
      rd(tmd_pkg::HREG_STAT, d);
      if (d[0] === 1'b0) break;
    end
    `CHK(d[1:0], 2'b10)
    $display("test sync transmit done");
    wr(4'h6, 8'h0C);
    wr(4'h0, 8'h0C);
    @(posedge clk) i_chan <= 1'b0;
    wt(4);
    @(posedge clk) i_chan <= 1'b1;
    for (i = 0; i < 3; i++) rise(n);
    `CHK(n, 128)
    `CHK({lnk.data_io_pin, bsync}, 2'b11)
    $display("test sync receive done");
    wr(tmd_pkg::HREG_CTRL, 8'h02);
    rd(tmd_pkg::HREG_CTRL, d);
    `CHK(d, 8'h02)
    rd(tmd_pkg::HREG_TXD, d);
    `CHK(d, 8'h5A)
    // First byte all ones, then demod forced to 0; the byte after the
    // switch may be mixed, the one after it must be all zeros
    for (n = 0; n < 3; n++) begin
      for (i = 0; i < 1500; i++) begin
        rd(tmd_pkg::HREG_STAT, d);
        if (d[2] === 1'b1) break;
      end
      `CHK(d[2], 1'b1)
      wr(tmd_pkg::HREG_STAT, 8'h04);
      rd(tmd_pkg::HREG_RXD, v);
      if (n == 0) begin
        `CHK(v, 8'hFF)
        @(posedge clk) q_chan <= 1'b0;
        wt(4);
        @(posedge clk) q_chan <= 1'b1;
      end
    end
    `CHK(v, 8'h00)
    rd(tmd_pkg::HREG_STAT, d);
    `CHK(d[2], 1'b0)
    $display("test host receive done");
    results;
  end

  initial begin
    #(8 * 20000);
    fails++;
    results;
  end
endmodule
`default_nettype wire
